// ==== hdl/boot_mode_strap_select.sv ====
// Purpose: Capture boot straps once at reset release and hold the mode
// Assumes: rst is the combined power-up and external reset, synchronous
// Notes:   Strobe pin is released during reset so the strap can be read
//
// Overview of operation
// - Read strobe strap only at reset release
// - Otherwise drive strap pin as strobe output
// - Low strap selects serial download mode
// - High strap runs stored user program
// - Debug entry identical to download entry
// - Debugger fully on chip, no external memory
// - Fetch-select strap picks internal/external memory
// - Emulation controller enabled by resistor-pulled strap
`timescale 1ns/1ps
`default_nettype none
module boot_mode_strap_select
(
   // Clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst,
   // Strobe strap pin (program_store_strobe_n)
   input  wire logic                      programStoreStrobeNIn,
   output logic                           programStoreStrobeNOut,
   output logic                           programStoreStrobeNOe,
   // Fetch-select strap pin (external_fetch_select_n)
   input  wire logic                      externalFetchSelectNIn,
   // Strobe request from the fetch unit, active low
   input  wire logic                      fetchStrobeN,
   // Emulator pull-up sense, high when pin is resistor-pulled
   input  wire logic                      emulPullSense,
   // Selected mode
   output boot_strap_pkg::bootMode_t      bootMode,
   output boot_strap_pkg::seqState_t      seqState
);
   import boot_strap_pkg::*;

   // Everything the selector remembers between edges, apart from the strap flops in u_sync
   typedef struct packed {
      seqState_t            st;
      logic [CNT_W-1:0]     cnt;
      bootMode_t            mode;
      pinDrive_t            strobe;
      logic                 emulMeta;
      logic                 emulSync;
   } state_t;

   state_t   s_q;
   state_t   s_d;
   strapIn_t pinRaw;
   strapIn_t pinSync;

   // Released pin: the jumper level must win while straps are read
   function automatic pinDrive_t releasedDrive();
      pinDrive_t d;
      d.out = 1'b1;
      d.oe  = 1'b0;
      return d;
   endfunction

   // Driven pin: follows the fetch unit's strobe request
   function automatic pinDrive_t strobeDrive
   (
      input logic reqN
   );
      pinDrive_t d;
      d.out = reqN;
      d.oe  = 1'b1;
      return d;
   endfunction

   // Last settle cycle, counter about to run out
   function automatic logic settleDone
   (
      input logic [CNT_W-1:0] count
   );
      return (count <= CNT_ONE);
   endfunction

   // Sequencer step, kept apart from the datapath below
   function automatic seqState_t nextStep
   (
      input seqState_t        cur,
      input logic [CNT_W-1:0] count
   );
      seqState_t nxt;
      nxt = cur;
      case (cur)
         ST_RESET:
         begin
            nxt = ST_SETTLE;
         end
         ST_SETTLE:
         begin
            if (settleDone(count))
            begin
               nxt = ST_SAMPLE;
            end
         end
         ST_SAMPLE:
         begin
            nxt = ST_RUN;
         end
         ST_RUN:
         begin
            nxt = ST_RUN;
         end
         default:
         begin
            nxt = ST_RESET;
         end
      endcase
      return nxt;
   endfunction

   // Mode decode from the synchronised straps
   function automatic bootMode_t modeFromStraps
   (
      input strapIn_t straps,
      input logic     pulled
   );
      bootMode_t m;
      m               = MODE_RESET;
      m.valid         = 1'b1;
      // low strap, loader waits on UART
      // loader and debugger live on chip
      m.downloadMode  = ~straps.strobeStrapN;
      m.userRun       = straps.strobeStrapN;
      m.internalFetch = straps.fetchSelN;
      m.emulationEn   = straps.fetchSelN & pulled;
      return m;
   endfunction

   // Register contents while rst is high
   function automatic state_t resetState();
      state_t r;
      r.st       = ST_RESET;
      r.cnt      = CNT_ZERO;
      r.mode     = MODE_RESET;
      r.strobe   = releasedDrive();
      r.emulMeta = 1'b0;
      r.emulSync = 1'b0;
      return r;
   endfunction

   // Strap pins gathered for the synchroniser
   always_comb
   begin
      pinRaw.strobeStrapN = programStoreStrobeNIn;
      pinRaw.fetchSelN    = externalFetchSelectNIn;
   end

   strap_sync u_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pinRaw   (pinRaw),
      .pinSync  (pinSync)
   );

   always_comb
   begin
      s_d          = s_q;
      s_d.st       = nextStep(s_q.st, s_q.cnt);

      // Pull-up sense is asynchronous: two flops before use
      s_d.emulMeta = emulPullSense;
      s_d.emulSync = s_q.emulMeta;

      case (s_q.st)
         ST_RESET:
         begin
            // Pin released so the jumper level can be seen
            s_d.strobe = releasedDrive();
            s_d.cnt    = SETTLE_CYC;
         end

         ST_SETTLE:
         begin
            // Wait out the synchroniser and pin settling
            s_d.cnt = s_q.cnt - CNT_ONE;
         end

         ST_SAMPLE:
         begin
            s_d.mode = modeFromStraps(pinSync, s_q.emulSync);
         end

         ST_RUN:
         begin
            // board keeps pin free; strap ignored now
            s_d.strobe = strobeDrive(fetchStrobeN);
            s_d.mode   = s_q.mode;
         end

         default:
         begin
            s_d = resetState();
         end
      endcase
   end

   // Synchronous reset only, straps re-read on every release
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_q <= resetState();
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign programStoreStrobeNOut = s_q.strobe.out;
   assign programStoreStrobeNOe  = s_q.strobe.oe;
   assign bootMode               = s_q.mode;
   assign seqState               = s_q.st;

endmodule // boot_mode_strap_select
`default_nettype wire

// ==== hdl/boot_strap_pkg.sv ====
// Purpose: Shared types and constants for reset-time boot mode selection
// Assumes: Single core clock, synchronous active-high reset
// Notes:   Strap pins are asynchronous and pass a two-stage synchroniser
package boot_strap_pkg;

   localparam int unsigned CLK_HZ        = 50000000;
   // Settle time after reset release before straps are trusted
   localparam int unsigned SETTLE_NS     = 100;
   localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   localparam int unsigned SETTLE_CYC_I  =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W         = 4;
   localparam logic [CNT_W-1:0] SETTLE_CYC = CNT_W'(SETTLE_CYC_I);
   localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

   // Sequencer states, one-hot
   typedef enum logic [3:0] {
      ST_RESET  = 4'h1,
      ST_SETTLE = 4'h2,
      ST_SAMPLE = 4'h4,
      ST_RUN    = 4'h8
   } seqState_t;

   // Mode chosen at reset release
   typedef struct packed {
      logic valid;        // Selection captured
      logic downloadMode; // Serial download / debug loader
      logic userRun;      // Execute user program
      logic internalFetch;// Fetch from internal program store
      logic emulationEn;  // Single-pin emulation controller enabled
   } bootMode_t;

   localparam bootMode_t MODE_RESET = '{default: 1'b0};

   // Strap pin samples after synchronisation
   typedef struct packed {
      logic strobeStrapN;
      logic fetchSelN;
   } strapIn_t;

   // Strobe pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } pinDrive_t;

endpackage

// ==== hdl/strap_sync.sv ====
// Purpose: Two-flop synchroniser for the strap pins
// Assumes: Pins are asynchronous to core_clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module strap_sync
(
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // Raw and synchronised pins
   input  wire boot_strap_pkg::strapIn_t pinRaw,
   output var  boot_strap_pkg::strapIn_t pinSync
);
   import boot_strap_pkg::*;

   typedef struct packed {
      strapIn_t meta;
      strapIn_t sync;
   } syncState_t;

   syncState_t s_q;
   syncState_t s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.meta = pinRaw;
      s_d.sync = s_q.meta;
   end

   // Idle-high reset value: pins pulled high when undriven
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_q <= '{meta: '{default: 1'b1}, sync: '{default: 1'b1}};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign pinSync = s_q.sync;

endmodule // strap_sync
`default_nettype wire

// ==== sim/strap_board.sv ====
// Purpose: Board straps and emulator pull-up facing the device
// Assumes: Pins are static during a boot
// Notes:   Strobe pin idles high unless the jumper is fitted
`timescale 1ns/1ps
`default_nettype none
module strap_board
(
   // Board settings
   input  wire logic jumperOn,
   input  wire logic fetchHigh,
   input  wire logic viaResistor,
   // Device drive of the strobe pin
   input  wire logic strobeOut,
   input  wire logic strobeOe,
   // Levels at the device
   output logic      strobePin,
   output logic      fetchPin,
   output logic      pullSense
);
   assign strobePin = strobeOe ? strobeOut : !jumperOn;
   assign fetchPin  = fetchHigh;
   assign pullSense = fetchHigh && viaResistor;
endmodule // strap_board
`default_nettype wire

// ==== sim/boot_mode_strap_select_sva.sv ====
// Purpose: Port checks for the boot strap selector
// Assumes: One clock, synchronous reset
// Notes:   Bound onto every instance
`timescale 1ns/1ps
`default_nettype none
module boot_mode_strap_select_sva
(
   input wire logic                      core_clk,
   input wire logic                      rst,
   input wire logic                      programStoreStrobeNOut,
   input wire logic                      programStoreStrobeNOe,
   input wire logic                      fetchStrobeN,
   input wire boot_strap_pkg::bootMode_t bootMode,
   input wire boot_strap_pkg::seqState_t seqState
);
   import boot_strap_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_oe_idle: assert property (seqState != ST_RUN |-> !programStoreStrobeNOe)
      else $error("strobe driven outside run");
   a_oe_run: assert property ($past(seqState) == ST_RUN |-> programStoreStrobeNOe)
      else $error("strobe not driven in run");
   a_strobe_pass: assert property (programStoreStrobeNOe |-> programStoreStrobeNOut == $past(fetchStrobeN))
      else $error("strobe not following fetch");
   a_mode_hold: assert property ($past(bootMode.valid) |-> $stable(bootMode))
      else $error("mode changed after capture");
   a_valid_run: assert property (seqState == ST_RUN |-> bootMode.valid)
      else $error("run without mode");
   a_mode_excl: assert property (bootMode.valid |-> bootMode.downloadMode ^ bootMode.userRun)
      else $error("download and user run clash");
   a_emul_fetch: assert property (bootMode.emulationEn |-> bootMode.internalFetch)
      else $error("emulation with hardwired low");
   a_sample_once: assert property ($rose(bootMode.valid) |-> $past(seqState, 2) == ST_SETTLE)
      else $error("capture not right after settle");
endmodule // boot_mode_strap_select_sva
bind boot_mode_strap_select boot_mode_strap_select_sva i_sva (.core_clk(core_clk), .rst(rst),
   .programStoreStrobeNOut(programStoreStrobeNOut), .programStoreStrobeNOe(programStoreStrobeNOe),
   .fetchStrobeN(fetchStrobeN), .bootMode(bootMode), .seqState(seqState));
`default_nettype wire

// ==== sim/boot_mode_strap_select_test.sv ====
// Purpose: Boots in download (external fetch), internal user-run and emulation set-ups
// Assumes: Straps held from reset until run
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin nMismatch++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module boot_mode_strap_select_test;
   import boot_strap_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, fetchStrobeN = 1'b1;
   logic jumperOn = 1'b0, fetchHigh = 1'b1, viaResistor = 1'b0;
   logic pin, oe, out, fetchPin, sense;
   bootMode_t bootMode;
   seqState_t seqState;
   int nMismatch = 0, checksDone = 0, cyc = 0;
   strap_board i_board (.jumperOn(jumperOn), .fetchHigh(fetchHigh), .viaResistor(viaResistor),
      .strobeOut(out), .strobeOe(oe), .strobePin(pin), .fetchPin(fetchPin), .pullSense(sense));
   boot_mode_strap_select i_dut (.core_clk(core_clk), .rst(rst), .programStoreStrobeNIn(pin),
      .programStoreStrobeNOut(out), .programStoreStrobeNOe(oe), .externalFetchSelectNIn(fetchPin),
      .fetchStrobeN(fetchStrobeN), .emulPullSense(sense), .bootMode(bootMode), .seqState(seqState));
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", checksDone, nMismatch);
      if (nMismatch == 0 && checksDone > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic boot(input logic j, input logic f, input logic r);
      logic [4:0] exp;
      exp = {1'b1, j, !j, f, f & r};
      @(negedge core_clk);
      rst = 1'b1; jumperOn = j; fetchHigh = f; viaResistor = r;
      repeat (3) @(negedge core_clk);
      `CHK("oe", 1'b0, oe)
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      `CHK("mode", exp, bootMode)
      `CHK("state", ST_RUN, seqState)
      jumperOn = !j; fetchHigh = !f; fetchStrobeN = 1'b0;
      repeat (3) @(negedge core_clk);
      `CHK("held", exp, bootMode)
      `CHK("strobe", 1'b0, pin)
      fetchStrobeN = 1'b1;
      $display("boot %b%b%b done", j, f, r);
   endtask
   initial
   begin
      forever #10 core_clk = !core_clk;
   end
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         nMismatch++;
         wrapUp();
      end
   end
   initial
   begin
      repeat (12) @(negedge core_clk);
      boot(1'b1, 1'b0, 1'b0);
      boot(1'b0, 1'b1, 1'b0);
      boot(1'b0, 1'b1, 1'b1);
      wrapUp();
   end
endmodule // boot_mode_strap_select_test
`default_nettype wire
